// ===== src/dsp_acc_pkg.sv
// package for the dsp accumulator: widths, field positions, reset value, op codes
// assumes the core decode presents one operation code per cycle
package dsp_acc_pkg;
	localparam int          ACC_W      = 64;
	localparam int          WORD_W     = 32;
	localparam int          HI_LSB     = 32;
	localparam int          MID_LSB    = 16;
	localparam logic [63:0] ACC_RESET  = 64'h0;
	localparam int          OP_W       = 4;

	typedef enum logic [3:0] {
		op_none                  = 4'h0,
		signed_wide_product_op   = 4'h1,
		unsigned_wide_product_op = 4'h2,
		float_product_op         = 4'h3,
		integer_product_op       = 4'h4,
		repeated_product_sum_op  = 4'h5,
		write_upper_word         = 4'h6,
		write_lower_word         = 4'h7,
		read_upper_word          = 4'h8,
		read_middle_word         = 4'h9
	} acc_op_t;
endpackage

// ===== src/acc_word_select.sv
// word select: picks the upper or middle 32-bit slice of the accumulator
// assumes a registered accumulator value at its input
`timescale 1ns/1ps
module acc_word_select (
	// accumulator value
	input  wire logic [63:0] acc_value,
	// slice choice: high picks middle slice
	input  wire logic        pick_middle,
	// selected word
	output logic      [31:0] word
);
	assign word = pick_middle ? acc_value[dsp_acc_pkg::MID_LSB +: dsp_acc_pkg::WORD_W]
	                          : acc_value[dsp_acc_pkg::HI_LSB +: dsp_acc_pkg::WORD_W];
endmodule

// ===== src/dsp_sum_register.sv
// dsp accumulator register of the core, driven only by instruction execution
// assumes op, operand and product come from execute, synchronous to mclk
// limits: sums wrap at 64 bits; codes outside the table are ignored
`timescale 1ns/1ps
module dsp_sum_register (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// request from execute
	input  wire logic [3:0]  op,
	input  wire logic [31:0] operand,
	input  wire logic [63:0] product,
	input  wire logic        accumulate,
	// answer to execute
	output logic      [31:0] read_data,
	output logic             read_valid,
	output logic      [63:0] acc_value
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [63:0] acc;
		logic [31:0] rdata;
		logic        rvalid;
	} state_t;

	localparam int HALF_W = dsp_acc_pkg::WORD_W;

	// ----------------------------------------
	// operation classes
	// ----------------------------------------
	// execute issues one operation per edge, so at most one class is live;
	// a read therefore always sees the value before any same-edge update
	typedef enum logic [1:0] {
		cls_idle    = 2'b00,
		cls_product = 2'b01,
		cls_write   = 2'b10,
		cls_read    = 2'b11
	} op_class_t;

	// registered state and its next value
	state_t      cur;
	state_t      next_cur;

	// decode and datapath
	logic [31:0] sel_word;
	logic        is_mid;
	op_class_t   op_class;
	logic        dec_add;
	logic [1:0]  half_hit;
	logic [63:0] merged;
	logic [63:0] sum_value;
	logic [63:0] prod_value;

	// ----------------------------------------
	// decode functions
	// ----------------------------------------

	function automatic logic is_product(input logic [3:0] code);
		case (dsp_acc_pkg::acc_op_t'(code))
			dsp_acc_pkg::signed_wide_product_op,
			dsp_acc_pkg::unsigned_wide_product_op,
			dsp_acc_pkg::float_product_op,
			dsp_acc_pkg::integer_product_op,
			dsp_acc_pkg::repeated_product_sum_op: is_product = 1'b1;
			default: is_product = 1'b0;
		endcase
	endfunction

	function automatic logic is_read(input logic [3:0] code);
		case (dsp_acc_pkg::acc_op_t'(code))
			dsp_acc_pkg::read_upper_word,
			dsp_acc_pkg::read_middle_word: begin
				is_read = 1'b1;
			end
			default: begin
				is_read = 1'b0;
			end
		endcase
	endfunction

	// half 1 is bits 63 to 32, half 0 is bits 31 to 0
	function automatic logic writes_half(input logic [3:0] code, input int half);
		case (dsp_acc_pkg::acc_op_t'(code))
			dsp_acc_pkg::write_upper_word: begin
				writes_half = (half == 1);
			end
			dsp_acc_pkg::write_lower_word: begin
				writes_half = (half == 0);
			end
			default: begin
				writes_half = 1'b0;
			end
		endcase
	endfunction

	function automatic logic is_write(input logic [3:0] code);
		is_write = writes_half(code, 0) || writes_half(code, 1);
	endfunction

	// product-sum always adds, whatever the accumulate input says
	function automatic logic always_adds(input logic [3:0] code);
		case (dsp_acc_pkg::acc_op_t'(code))
			dsp_acc_pkg::repeated_product_sum_op: begin
				always_adds = 1'b1;
			end
			default: begin
				always_adds = 1'b0;
			end
		endcase
	endfunction

	// unknown codes fall to idle: they are ignored and change nothing
	function automatic op_class_t classify(input logic [3:0] code);
		if (is_product(code)) begin
			classify = cls_product;
		end else if (is_read(code)) begin
			classify = cls_read;
		end else if (is_write(code)) begin
			classify = cls_write;
		end else begin
			classify = cls_idle;
		end
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign op_class = classify(op);
	assign is_mid   = (op == dsp_acc_pkg::read_middle_word);

	// the other products add only when execute asks for it
	assign dec_add  = (op_class == cls_product)
	                  && (accumulate || always_adds(op));

	// ----------------------------------------
	// product path
	// ----------------------------------------
	// the multiplier hands over a finished product; only the add lives here
	// the sum wraps at 64 bits; no carry or overflow flag leaves this block
	assign sum_value  = 64'(cur.acc + product);
	assign prod_value = dec_add ? sum_value : product;

	// ----------------------------------------
	// half-word writes
	// ----------------------------------------
	// each half takes the operand only when addressed, so the other keeps its bits
	genvar h;
	generate
		for (h = 0; h < dsp_acc_pkg::ACC_W / HALF_W; h = h + 1) begin : g_half
			assign half_hit[h] = writes_half(op, h);
			assign merged[h*HALF_W +: HALF_W] = half_hit[h]
			                                    ? operand
			                                    : cur.acc[h*HALF_W +: HALF_W];
		end
	endgenerate

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// slice is taken from the registered value, never from next_cur

	acc_word_select u_sel (
		.acc_value   (cur.acc),
		.pick_middle (is_mid),
		.word        (sel_word)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_cur        = cur;
		next_cur.rvalid = 1'b0;
		case (op_class)
			cls_product: begin
				next_cur.acc = prod_value;
			end
			cls_write: begin
				next_cur.acc = merged;
			end
			cls_read: begin
				// read data holds until the next read; valid stands one cycle
				next_cur.rdata  = sel_word;
				next_cur.rvalid = 1'b1;
			end
			cls_idle: begin
				// accumulator and read data simply hold
				next_cur.rvalid = 1'b0;
			end
			default: begin
				next_cur.rvalid = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cur.acc    <= dsp_acc_pkg::ACC_RESET;
			cur.rdata  <= 32'h0;
			cur.rvalid <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign read_data  = cur.rdata;
	assign read_valid = cur.rvalid;
	assign acc_value  = cur.acc;
endmodule

// ===== sim/acc_chk_sva.sv
// checker on accumulator ports
// assumes bind to dsp_sum_register
`timescale 1ns/1ps
module acc_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_b,
	// request from execute
	input wire logic [3:0]  op,
	input wire logic [31:0] operand,
	input wire logic [63:0] product,
	input wire logic        accumulate,
	// answer to execute
	input wire logic [31:0] read_data,
	input wire logic        read_valid,
	input wire logic [63:0] acc_value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_hi_write: assert property (op==4'h6 |=> acc_value==
		{$past(operand),$past(acc_value[31:0])}) else $error("hi write");
	a_lo_write: assert property (op==4'h7 |=> acc_value==
		{$past(acc_value[63:32]),$past(operand)}) else $error("lo write");
	a_hi_read: assert property (op==4'h8 |=> read_valid &&
		read_data==$past(acc_value[63:32])) else $error("hi read");
	a_mid_read: assert property (op==4'h9 |=> read_valid &&
		read_data==$past(acc_value[47:16])) else $error("mid read");
	a_prod_over: assert property (op inside {[1:4]} && !accumulate
		|=> acc_value==$past(product)) else $error("overwrite");
	a_sum_add: assert property (op==4'h5 |=> acc_value==
		$past(acc_value)+$past(product)) else $error("sum");
	a_acc_hold: assert property (op==4'h0 || op>4'h7
		|=> $stable(acc_value)) else $error("hold");
	a_valid_pulse: assert property (!(op inside {4'h8, 4'h9}) |=> !read_valid)
		else $error("read valid without a read");
	a_rdata_hold: assert property (!(op inside {4'h8, 4'h9}) |=> $stable(read_data))
		else $error("read data moved without a read");
	c_read: cover property (read_valid);
	c_sum: cover property (op==4'h5);
	c_acc: cover property (op==4'h4 && accumulate);
endmodule
bind dsp_sum_register acc_chk u_acc_chk (
	.mclk       (mclk),
	.rst_b      (rst_b),
	.op         (op),
	.operand    (operand),
	.product    (product),
	.accumulate (accumulate),
	.read_data  (read_data),
	.read_valid (read_valid),
	.acc_value  (acc_value)
);

// ===== sim/exec_model.sv
// execute stage model: one op per cycle
// assumes requests only after reset release
`timescale 1ns/1ps
module exec_model (
	input  wire logic        mclk,
	output logic      [3:0]  op = 4'h0,
	output logic      [31:0] operand = 32'h0,
	output logic      [63:0] product = 64'h0,
	output logic             accumulate = 1'b0
);
	task automatic issue(input logic [3:0] o, input logic [31:0] d,
		input logic [63:0] p, input logic a);
		@(posedge mclk) #1;
		{op, operand, product, accumulate} = {o, d, p, a};
	endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the accumulator
// assumes exec_model drives every request
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0, rst_b = 1'b0, accumulate, read_valid;
	logic [3:0]  op;
	logic [31:0] operand, read_data;
	logic [63:0] product, acc_value;
	int          errors = 0, n_checks = 0, cyc = 0;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) if (++cyc > 400) begin
		errors++;
		end_of_test();
	end
	exec_model u_exec_model (
		.mclk       (mclk),
		.op         (op),
		.operand    (operand),
		.product    (product),
		.accumulate (accumulate)
	);
	dsp_sum_register u_dsp_sum_register (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.op         (op),
		.operand    (operand),
		.product    (product),
		.accumulate (accumulate),
		.read_data  (read_data),
		.read_valid (read_valid),
		.acc_value  (acc_value)
	);
	task automatic chk(input logic [63:0] s, input logic [63:0] x);
		n_checks++;
		if (s !== x) begin
			errors++;
			$display("ERROR %0t: saw %h want %h", $time, s, x);
		end
	endtask
	// released data inverted so stale values never pass
	task automatic op1(input logic [3:0] o, input logic [31:0] d, input logic [63:0] p);
		u_exec_model.issue(o, d, p, p[0]);
		u_exec_model.issue(4'h0, ~d, ~p, 1'b0);
	endtask
	task automatic test_reset;
		chk(acc_value, dsp_acc_pkg::ACC_RESET);
		chk({read_valid, read_data}, 64'h0);
		$display("test reset done");
	endtask
	task automatic test_half_writes;
		op1(dsp_acc_pkg::write_upper_word, 32'h0f1e_2d3c, 64'h0);
		chk(acc_value, 64'h0f1e2d3c_00000000);
		op1(dsp_acc_pkg::write_lower_word, 32'h1234_5678, 64'h0);
		chk(acc_value, 64'h0f1e2d3c_12345678);
		op1(dsp_acc_pkg::write_upper_word, 32'h89ab_cdef, 64'h0);
		chk(acc_value, 64'h89abcdef_12345678);
		$display("test half writes done");
	endtask
	task automatic test_reads;
		op1(dsp_acc_pkg::read_middle_word, 32'h0, 64'h0);
		chk({read_valid, read_data}, {1'b1, 32'hcdef_1234});
		op1(dsp_acc_pkg::read_upper_word, 32'h0, 64'h0);
		chk({read_valid, read_data}, {1'b1, 32'h89ab_cdef});
		$display("test reads done");
	endtask
	task automatic test_refused;
		op1(4'hf, 32'h0, 64'h0);
		chk(acc_value, 64'h89abcdef_12345678);
		chk({read_valid, read_data}, {1'b0, 32'h89ab_cdef});
		op1(4'ha, 32'hffff_ffff, 64'hffff_ffff_ffff_fffe);
		chk(acc_value, 64'h89abcdef_12345678);
		$display("test refused done");
	endtask
	task automatic test_products;
		logic [63:0] p;
		logic [63:0] e;
		e = 64'h0;
		// codes 1..4 overwrite, product-sum adds, last pass adds by accumulate
		for (int i = 1; i <= 6; i++) begin
			p = {8'(i), 56'h10_0000_0000_0002} | 64'((i == 6) ? 1 : 0);
			e = (i >= 5) ? 64'(e + p) : p;
			op1(4'((i == 6) ? 4 : i), 32'h0, p);
			chk(acc_value, e);
		end
		$display("test products done");
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		#1 rst_b = 1'b1;
		test_reset();
		test_half_writes();
		test_reads();
		test_refused();
		test_products();
		end_of_test();
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
endmodule
